// ---- rtl/sth_defs.vh ----
// Constants shared by the safe torque off / safe halt logic.
// Assumes one 200 MHz system clock and active-low command pins.
`ifndef STH_DEFS_VH
`define STH_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STH_CLK_PERIOD_NS   5
`define STH_TICK_TIME_NS    1000000
`define STH_TICK_CYCLES     (`STH_TICK_TIME_NS / `STH_CLK_PERIOD_NS)
`define STH_TIME_W          16

// ----------------------------------------------------------------
// Supervisor states
// ----------------------------------------------------------------
`define STH_ST_W            2
`define STH_ST_RUN          2'h0
`define STH_ST_HALT         2'h1
`define STH_ST_TOFF         2'h2

// ----------------------------------------------------------------
// Stop methods
// ----------------------------------------------------------------
`define STH_METH_W          2
`define STH_METH_NONE       2'h0
`define STH_METH_DB         2'h1
`define STH_METH_EDB        2'h2
`define STH_METH_SD         2'h3

// ----------------------------------------------------------------
// Torque off cause codes
// ----------------------------------------------------------------
`define STH_CAUSE_W         2
`define STH_CAUSE_NONE      2'h0
`define STH_CAUSE_CMD       2'h1
`define STH_CAUSE_ALARM     2'h2
`define STH_CAUSE_HALT      2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STH_SYNC_RST        1'b0
`define STH_CNT_ZERO        16'h0000

`endif

// ---- rtl/sth_sync2.v ----
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/1ps
`include "sth_defs.vh"

module sth_sync2 #(
    parameter WIDTH = 2
) (
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] meta_reg;

    // Reset to "off" so torque stays removed until the pins are seen on
    always @(posedge clk_sys) begin
        if (!nrst) begin
            meta_reg  <= {WIDTH{`STH_SYNC_RST}};
            level_out <= {WIDTH{`STH_SYNC_RST}};
        end else begin
            meta_reg  <= pin_in;
            level_out <= meta_reg;
        end
    end

endmodule // sth_sync2

// ---- rtl/sth_halt_timer.v ----
// Safe halt monitoring timer: millisecond divider and elapsed counter.
// Assumes run is a level from the same clock; dropping it clears all.
`timescale 1ns/1ps
`include "sth_defs.vh"

module sth_halt_timer #(
    parameter TICK_CYCLES = `STH_TICK_CYCLES,
    parameter DIV_W       = 18,
    parameter TIME_W      = `STH_TIME_W
) (
    input  wire              clk_sys,
    input  wire              nrst,
    input  wire              run,
    input  wire [TIME_W-1:0] limit,
    output reg               expired,
    output reg  [TIME_W-1:0] elapsed
);

    localparam integer     LAST_I   = TICK_CYCLES - 1;
    localparam [DIV_W-1:0] DIV_LAST = LAST_I[DIV_W-1:0];

    reg  [DIV_W-1:0] div_reg;
    wire             tick;

    assign tick = (div_reg == DIV_LAST);

    always @(posedge clk_sys) begin
        if (!nrst || !run) begin
            div_reg <= {DIV_W{1'b0}};
            elapsed <= {TIME_W{1'b0}};
            expired <= 1'b0;
        end else begin
            div_reg <= tick ? {DIV_W{1'b0}} : div_reg + 1'b1;
            // Saturates at the limit so a long halt never wraps back
            if (tick && (elapsed < limit)) begin
                elapsed <= elapsed + 1'b1;
            end
            expired <= (elapsed >= limit);
        end
    end

endmodule // sth_halt_timer

// ---- rtl/sth_safety_ctrl.v ----
// Safe torque off and timed safe halt supervisor with stop method choice.
// Assumes command pins are asynchronous; alarms, motor_running, mode and
// configuration inputs come from logic on clk_sys.
`timescale 1ns/1ps
`include "sth_defs.vh"

// How it works
// - Torque off engages whenever the torque off command pin is low.
// - During torque off, drive energy stays cut and dynamic brake stays on.
// - Torque off command high again returns to normal operation.
// - A torque-off-class alarm engages torque off regardless of the command.
// - Command dropped while the motor runs raises the timing alarm.
// - Safe halt starts whenever the safe halt command pin is low.
// - Safe halt decelerates with dynamic, electronic brake or forced decel.
// - Safe halt timer reaching the monitoring time engages torque off.
// - Safe halt command high again ends safe halt, normal operation resumes.
// - A safe-halt-class alarm starts the same halt and timed torque off.
// - Stop method depends on two settings, capacity, mode and trigger.
// - Forced decel on: torque mode electronic brake if automatic and small, else dynamic.
// - Non-torque electronic-brake-class alarms: electronic brake if automatic and small.
// - Forced decel off: electronic brake if automatic and small, else dynamic.
// - Alarm triggers feed their own stop class into the method choice.
// - Dynamic brake chosen but not fitted: motor coasts, energy removed.
module sth_safety_ctrl #(
    parameter TICK_CYCLES = `STH_TICK_CYCLES,
    parameter TIME_W      = `STH_TIME_W
) (
    input  wire                    clk_sys,
    input  wire                    nrst,
    input  wire                    safe_torque_off_command,
    input  wire                    safe_halt1_command,
    input  wire                    alarm_torque_off,
    input  wire                    alarm_safe_halt,
    input  wire                    alarm_class_edb,
    input  wire                    motor_running,
    input  wire                    timing_alarm_clear,
    input  wire                    forced_stop_decel_select_param,
    input  wire                    electronic_brake_select_param,
    input  wire                    capacity_small,
    input  wire                    torque_mode,
    input  wire                    db_fitted,
    input  wire [TIME_W-1:0]       monitoring_decel_time_param,
    output reg                     drive_energy_on,
    output reg                     dynamic_brake_on,
    output reg                     electronic_brake_on,
    output reg                     forced_decel_request,
    output reg                     torque_off_status_output,
    output reg                     safe_halt1_status,
    output reg  [`STH_METH_W-1:0]  halt_method,
    output wire [`STH_METH_W-1:0]  halt_method_preview,
    output reg  [`STH_CAUSE_W-1:0] torque_off_cause,
    output reg                     torque_off_timing_alarm,
    output wire [TIME_W-1:0]       halt_elapsed
);

    // ----------------------------------------------------------------
    // Stop method choice
    // ----------------------------------------------------------------
    function [`STH_METH_W-1:0] pick_method;
        input fsd_en;
        input edb_auto;
        input cap_small;
        input torque;
        input by_alarm;
        input alarm_edb;
        reg   edb_ok;
        begin
            edb_ok = edb_auto & cap_small;
            if (!fsd_en || torque || (by_alarm && alarm_edb)) begin
                pick_method = edb_ok ? `STH_METH_EDB : `STH_METH_DB;
            end else begin
                pick_method = `STH_METH_SD;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire [1:0] cmd_sync;
    wire       sto_cmd_on;
    wire       halt_cmd_on;

    sth_sync2 #(
        .WIDTH     (2)
    ) u_sync (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .pin_in    ({safe_halt1_command, safe_torque_off_command}),
        .level_out (cmd_sync)
    );

    assign sto_cmd_on  = cmd_sync[0];
    assign halt_cmd_on = cmd_sync[1];

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    reg  sto_cmd_prev_reg;
    wire sto_cmd_fall;
    wire sto_req;
    wire halt_req;
    wire halt_by_alarm;

    assign sto_cmd_fall  = sto_cmd_prev_reg & ~sto_cmd_on;
    assign sto_req       = ~sto_cmd_on | alarm_torque_off;
    assign halt_req      = ~halt_cmd_on | alarm_safe_halt;
    assign halt_by_alarm = alarm_safe_halt;

    assign halt_method_preview = pick_method(forced_stop_decel_select_param,
                                             electronic_brake_select_param,
                                             capacity_small,
                                             torque_mode,
                                             halt_by_alarm,
                                             alarm_class_edb);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            sto_cmd_prev_reg <= `STH_SYNC_RST;
        end else begin
            sto_cmd_prev_reg <= sto_cmd_on;
        end
    end

    // ----------------------------------------------------------------
    // Monitoring timer
    // ----------------------------------------------------------------
    reg  [`STH_ST_W-1:0] state_reg;
    reg  [`STH_ST_W-1:0] state_next;
    wire                 halt_expired;
    wire                 timer_run;

    // Runs only while halting; any exit clears it
    assign timer_run = (state_reg == `STH_ST_HALT) && halt_req;

    sth_halt_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .DIV_W       (18),
        .TIME_W      (TIME_W)
    ) u_timer (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .run         (timer_run),
        .limit       (monitoring_decel_time_param),
        .expired     (halt_expired),
        .elapsed     (halt_elapsed)
    );

    // ----------------------------------------------------------------
    // Supervisor state machine
    // ----------------------------------------------------------------
    reg  [`STH_CAUSE_W-1:0] cause_next;
    reg                     halt_timed_out_reg;

    always @* begin
        state_next = state_reg;
        cause_next = torque_off_cause;
        case (state_reg)
            `STH_ST_RUN: begin
                if (sto_req) begin
                    state_next = `STH_ST_TOFF;
                    cause_next = alarm_torque_off ? `STH_CAUSE_ALARM : `STH_CAUSE_CMD;
                end else if (halt_req) begin
                    state_next = `STH_ST_HALT;
                end
            end
            `STH_ST_HALT: begin
                if (sto_req) begin
                    state_next = `STH_ST_TOFF;
                    cause_next = alarm_torque_off ? `STH_CAUSE_ALARM : `STH_CAUSE_CMD;
                end else if (!halt_req) begin
                    state_next = `STH_ST_RUN;
                end else if (halt_expired) begin
                    state_next = `STH_ST_TOFF;
                    cause_next = `STH_CAUSE_HALT;
                end
            end
            `STH_ST_TOFF: begin
                // Stays off while any source still asks for it
                if (!sto_req && !(halt_req && halt_timed_out_reg)) begin
                    state_next = halt_req ? `STH_ST_HALT : `STH_ST_RUN;
                    cause_next = `STH_CAUSE_NONE;
                end
            end
            default: begin
                state_next = `STH_ST_TOFF;
                cause_next = `STH_CAUSE_NONE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg          <= `STH_ST_TOFF;
            torque_off_cause   <= `STH_CAUSE_NONE;
            halt_timed_out_reg <= 1'b0;
        end else begin
            state_reg        <= state_next;
            torque_off_cause <= cause_next;
            // Remembers a timed-out halt until its request goes away
            if (!halt_req) begin
                halt_timed_out_reg <= 1'b0;
            end else if ((state_reg == `STH_ST_HALT) && halt_expired) begin
                halt_timed_out_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Method latch, captured when the halt begins
    // ----------------------------------------------------------------
    wire halt_entry;

    assign halt_entry = (state_reg != `STH_ST_HALT) && (state_next == `STH_ST_HALT);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            halt_method <= `STH_METH_NONE;
        end else if (halt_entry) begin
            halt_method <= halt_method_preview;
        end else if (state_next == `STH_ST_RUN) begin
            halt_method <= `STH_METH_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Drive outputs
    // ----------------------------------------------------------------
    reg [`STH_METH_W-1:0] meth_now;

    always @* begin
        meth_now = halt_entry ? halt_method_preview : halt_method;
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            drive_energy_on          <= 1'b0;
            dynamic_brake_on         <= 1'b1;
            electronic_brake_on      <= 1'b0;
            forced_decel_request     <= 1'b0;
            torque_off_status_output <= 1'b1;
            safe_halt1_status        <= 1'b0;
        end else begin
            case (state_next)
                `STH_ST_RUN: begin
                    drive_energy_on          <= 1'b1;
                    dynamic_brake_on         <= 1'b0;
                    electronic_brake_on      <= 1'b0;
                    forced_decel_request     <= 1'b0;
                    torque_off_status_output <= 1'b0;
                    safe_halt1_status        <= 1'b0;
                end
                `STH_ST_HALT: begin
                    // Energy stays only for ramped decel; brakes cut it
                    drive_energy_on          <= (meth_now == `STH_METH_SD);
                    dynamic_brake_on         <= (meth_now == `STH_METH_DB) && db_fitted;
                    electronic_brake_on      <= (meth_now == `STH_METH_EDB);
                    forced_decel_request     <= (meth_now == `STH_METH_SD);
                    torque_off_status_output <= 1'b0;
                    safe_halt1_status        <= 1'b1;
                end
                default: begin
                    drive_energy_on          <= 1'b0;
                    dynamic_brake_on         <= 1'b1;
                    electronic_brake_on      <= 1'b0;
                    forced_decel_request     <= 1'b0;
                    torque_off_status_output <= 1'b1;
                    safe_halt1_status        <= halt_req;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Torque off timing alarm
    // ----------------------------------------------------------------
    // Relies on the outside party keeping the motor still before it drops
    // the command; a drop while running is flagged, not prevented.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            torque_off_timing_alarm <= 1'b0;
        end else if (sto_cmd_fall && motor_running) begin
            torque_off_timing_alarm <= 1'b1;
        end else if (timing_alarm_clear) begin
            torque_off_timing_alarm <= 1'b0;
        end
    end

endmodule // sth_safety_ctrl

// ---- dv/sth_safety_ctrl_properties.sv ----
// Port-level assertions for the torque off / safe halt supervisor.
// Assumes one clock and the synchronous active-low reset of the design.
`timescale 1ns/1ps
`include "sth_defs.vh"
module sth_safety_props #(
    parameter TIME_W = 16
) (
    input wire              clk_sys,
    input wire              nrst,
    input wire              safe_torque_off_command,
    input wire              safe_halt1_command,
    input wire              alarm_torque_off,
    input wire              alarm_safe_halt,
    input wire              motor_running,
    input wire              db_fitted,
    input wire [TIME_W-1:0] monitoring_decel_time_param,
    input wire              drive_energy_on,
    input wire              dynamic_brake_on,
    input wire              electronic_brake_on,
    input wire              forced_decel_request,
    input wire              torque_off_status_output,
    input wire              safe_halt1_status,
    input wire [1:0]        halt_method,
    input wire              torque_off_timing_alarm,
    input wire [TIME_W-1:0] halt_elapsed
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Halt is live and not yet overtaken by torque off
    wire halting = safe_halt1_status && !torque_off_status_output;

    chk_sto_engage:
    assert property (!safe_torque_off_command [*4] |-> torque_off_status_output)
        else $error("torque off missing after command drop");
    chk_sto_energy_cut:
    assert property (torque_off_status_output |-> !drive_energy_on && dynamic_brake_on)
        else $error("energy or brake wrong in torque off");
    chk_sto_release:
    assert property ((safe_torque_off_command && safe_halt1_command && !alarm_torque_off
        && !alarm_safe_halt) [*5] |-> !torque_off_status_output)
        else $error("torque off held with no request");
    chk_alarm_sto:
    assert property (alarm_torque_off |=> torque_off_status_output)
        else $error("alarm did not engage torque off");
    chk_timing_alarm:
    assert property (($fell(safe_torque_off_command) && !torque_off_status_output)
        ##0 (motor_running && !safe_torque_off_command) [*3] |=> torque_off_timing_alarm)
        else $error("timing alarm missing");
    chk_halt_engage:
    assert property ((!torque_off_status_output && !safe_halt1_command
        && safe_torque_off_command && !alarm_torque_off)
        ##1 (!safe_halt1_command && safe_torque_off_command && !alarm_torque_off) [*3]
        |-> safe_halt1_status)
        else $error("safe halt not started");
    chk_halt_timeout:
    assert property (safe_halt1_status && !safe_halt1_command
        && halt_elapsed == monitoring_decel_time_param |-> ##[1:4] torque_off_status_output)
        else $error("no torque off after monitoring time");
    chk_halt_release:
    assert property ((safe_halt1_command && !alarm_safe_halt) [*5] |-> !safe_halt1_status)
        else $error("safe halt held with no request");
    chk_timer_clear:
    assert property ($fell(safe_halt1_status) |-> ##[0:2] halt_elapsed == `STH_CNT_ZERO)
        else $error("halt timer not cleared");
    chk_decel_drive:
    assert property (halting && halt_method == `STH_METH_SD
        |-> drive_energy_on && forced_decel_request)
        else $error("forced decel outputs wrong");
    chk_edb_drive:
    assert property (halting && halt_method == `STH_METH_EDB
        |-> electronic_brake_on && !drive_energy_on)
        else $error("electronic brake outputs wrong");
    chk_db_coast:
    assert property (halting && halt_method == `STH_METH_DB
        |-> dynamic_brake_on == db_fitted && !drive_energy_on)
        else $error("dynamic brake outputs wrong");

    cov_halt_timeout: cover property (safe_halt1_status && torque_off_status_output);
    cov_timing_alarm: cover property ($rose(torque_off_timing_alarm));
    cov_edb_halt: cover property (halting && halt_method == `STH_METH_EDB);
endmodule // sth_safety_props

bind sth_safety_ctrl sth_safety_props #(.TIME_W(TIME_W)) u_props (
    .clk_sys(clk_sys), .nrst(nrst), .safe_torque_off_command(safe_torque_off_command),
    .safe_halt1_command(safe_halt1_command), .alarm_torque_off(alarm_torque_off),
    .alarm_safe_halt(alarm_safe_halt), .motor_running(motor_running),
    .db_fitted(db_fitted), .monitoring_decel_time_param(monitoring_decel_time_param),
    .drive_energy_on(drive_energy_on), .dynamic_brake_on(dynamic_brake_on),
    .electronic_brake_on(electronic_brake_on), .forced_decel_request(forced_decel_request),
    .torque_off_status_output(torque_off_status_output),
    .safe_halt1_status(safe_halt1_status), .halt_method(halt_method),
    .torque_off_timing_alarm(torque_off_timing_alarm), .halt_elapsed(halt_elapsed));

// ---- dv/sth_safety_master.sv ----
// External safety switch model driving both command pins.
// Assumes the bench states its wishes as levels on clk_sys.
`timescale 1ns/1ps
module sth_safety_master (
    input  wire clk_sys,
    input  wire want_sto,
    input  wire want_halt,
    input  wire force_unsafe,
    input  wire slow,
    input  wire motor_running,
    output reg  safe_torque_off_command,
    output reg  safe_halt1_command
);
    reg [1:0] lag_reg;
    initial begin
        safe_torque_off_command = 1'b1;
        safe_halt1_command      = 1'b1;
        lag_reg                 = 2'h0;
    end
    // Slow mode acts on every fourth edge only
    always @(posedge clk_sys) begin
        lag_reg <= lag_reg + 2'h1;
        if (!slow || lag_reg == 2'h0) begin
            // Drop only at standstill, unless misuse is ordered
            if (want_sto && (!motor_running || force_unsafe))
                safe_torque_off_command <= 1'b0;
            else if (!want_sto)
                safe_torque_off_command <= 1'b1;
            safe_halt1_command <= !want_halt;
        end
    end
endmodule // sth_safety_master

// ---- dv/test_safe_torque_off_and_safe_halt1.sv ----
// Self-checking bench for the torque off / safe halt supervisor.
// Assumes a shortened millisecond tick of four clocks.
`timescale 1ns/1ps
`include "sth_defs.vh"
module test_safe_torque_off_and_safe_halt1;
    localparam TICK = 4;
    reg        clk_sys, nrst, want_sto, want_halt, force_unsafe, slow;
    reg        alarm_torque_off, alarm_safe_halt, alarm_class_edb, motor_running;
    reg        timing_alarm_clear, fsd_sel, edb_auto, capacity_small, torque_mode, db_fitted;
    reg [15:0] limit;
    reg [31:0] seed;
    reg [1:0]  em;
    wire       sto_cmd, halt_cmd, drive_energy_on, dynamic_brake_on, electronic_brake_on;
    wire       forced_decel_request, torque_off_status_output, safe_halt1_status, timing_alarm;
    wire [1:0] halt_method, cause, preview;
    wire [15:0] halt_elapsed;
    integer    fails, samples_checked, i, n;

    sth_safety_master partner (.clk_sys(clk_sys), .want_sto(want_sto), .want_halt(want_halt),
        .force_unsafe(force_unsafe), .slow(slow), .motor_running(motor_running),
        .safe_torque_off_command(sto_cmd), .safe_halt1_command(halt_cmd));
    sth_safety_ctrl #(.TICK_CYCLES(TICK)) dut (.clk_sys(clk_sys), .nrst(nrst),
        .safe_torque_off_command(sto_cmd), .safe_halt1_command(halt_cmd),
        .alarm_torque_off(alarm_torque_off), .alarm_safe_halt(alarm_safe_halt),
        .alarm_class_edb(alarm_class_edb), .motor_running(motor_running),
        .timing_alarm_clear(timing_alarm_clear), .forced_stop_decel_select_param(fsd_sel),
        .electronic_brake_select_param(edb_auto), .capacity_small(capacity_small),
        .torque_mode(torque_mode), .db_fitted(db_fitted), .monitoring_decel_time_param(limit),
        .drive_energy_on(drive_energy_on), .dynamic_brake_on(dynamic_brake_on),
        .electronic_brake_on(electronic_brake_on), .forced_decel_request(forced_decel_request),
        .torque_off_status_output(torque_off_status_output),
        .safe_halt1_status(safe_halt1_status), .halt_method(halt_method),
        .halt_method_preview(preview), .torque_off_cause(cause),
        .torque_off_timing_alarm(timing_alarm), .halt_elapsed(halt_elapsed));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    // Only forced decel, non-torque, non-EDB-class trigger ramps down
    function automatic logic [1:0] exp_method(input logic fsd, au, cap, tq, edb_alarm);
        if (fsd && !tq && !edb_alarm) exp_method = `STH_METH_SD;
        else exp_method = (au && cap) ? `STH_METH_EDB : `STH_METH_DB;
    endfunction
    task step; begin @(posedge clk_sys); #1; end endtask
    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin fails++; $display("Error %0t flag %b not %b", $time, got, exp); end
    endtask
    task automatic check_code(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin fails++; $display("Error %0t value %h not %h", $time, got, exp); end
    endtask
    task automatic wait_flag(input integer sel, input logic lvl);
        n = 0;
        while (((sel == 0) ? safe_halt1_status : torque_off_status_output) !== lvl && n < 300) begin
            step;
            n++;
        end
        if (n >= 300) begin fails++; $display("Error %0t wait ran out", $time); end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin clk_sys = 1'b0; forever #2.5 clk_sys = !clk_sys; end
    initial begin #300000; fails++; finish_test; end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {nrst, want_sto, want_halt, force_unsafe, slow, alarm_torque_off} = 6'h00;
        {alarm_safe_halt, alarm_class_edb, motor_running, timing_alarm_clear} = 4'h0;
        {fsd_sel, edb_auto, capacity_small, torque_mode, db_fitted} = 5'h00;
        fails = 0; samples_checked = 0; seed = 32'ha194; limit = 16'h00ff;
        repeat (16) step;
        check_flag(torque_off_status_output, 1);
        nrst = 1'b1;
        wait_flag(1, 0);
        check_flag(drive_energy_on, 1);
        for (i = 0; i < 48; i++) begin
            seed = xs(seed);
            {fsd_sel, edb_auto, capacity_small, torque_mode} = i[3:0];
            {db_fitted, motor_running, slow} = seed[2:0];
            alarm_class_edb = (i >= 32) || (seed[3] && i < 16);
            em = exp_method(fsd_sel, edb_auto, capacity_small, torque_mode, i >= 32);
            if (i < 16) want_halt = 1'b1; else alarm_safe_halt = 1'b1;
            wait_flag(0, 1);
            check_code(halt_method, em);
            check_code(preview, em);
            check_flag(drive_energy_on, em == `STH_METH_SD);
            check_flag(forced_decel_request, em == `STH_METH_SD);
            check_flag(electronic_brake_on, em == `STH_METH_EDB);
            check_flag(dynamic_brake_on, em == `STH_METH_DB && db_fitted);
            {want_halt, alarm_safe_halt} = 2'h0;
            wait_flag(0, 0);
            step;
            step;
            check_code(halt_elapsed, 16'h0000);
            check_flag(drive_energy_on, 1);
        end
        $display("method table test done");
        {slow, motor_running, fsd_sel, torque_mode} = 4'h2;
        for (i = 0; i < 3; i++) begin
            limit = (i == 0) ? 16'h0000 : {13'h0000, seed[6:4]} + 16'h0001;
            want_halt = 1'b1;
            wait_flag(0, 1);
            wait_flag(1, 1);
            check_flag(n + 6 >= limit * TICK && n <= limit * TICK + 6, 1);
            check_code(cause, `STH_CAUSE_HALT);
            want_halt = 1'b0;
            wait_flag(1, 0);
        end
        $display("halt timeout test done");
        {motor_running, want_sto} = 2'h1;
        wait_flag(1, 1);
        check_code(cause, `STH_CAUSE_CMD);
        check_flag(drive_energy_on, 0);
        check_flag(dynamic_brake_on, 1);
        check_flag(timing_alarm, 0);
        want_sto = 1'b0;
        wait_flag(1, 0);
        {motor_running, force_unsafe, want_sto} = 3'h7;
        wait_flag(1, 1);
        step;
        check_flag(timing_alarm, 1);
        {force_unsafe, want_sto, timing_alarm_clear} = 3'h1;
        step;
        timing_alarm_clear = 1'b0;
        step;
        check_flag(timing_alarm, 0);
        wait_flag(1, 0);
        $display("command torque off test done");
        alarm_torque_off = 1'b1;
        step;
        step;
        check_flag(torque_off_status_output, 1);
        check_code(cause, `STH_CAUSE_ALARM);
        alarm_torque_off = 1'b0;
        wait_flag(1, 0);
        $display("alarm torque off test done");
        finish_test;
    end
endmodule // test_safe_torque_off_and_safe_halt1
